// [rtl/flash_prot_pkg.sv]
// Constants, states and carriers for the sector write-protection block
package flash_prot_pkg;

  // Command opcodes; only the two gang codes are fixed, the rest are chosen values
  localparam logic [7:0] OP_WRITE_ENABLE = 8'hA0;
  localparam logic [7:0] OP_SCHEME_SEL = 8'hA1;
  localparam logic [7:0] OP_ENTER_OTP = 8'hA2;
  localparam logic [7:0] OP_LEAVE_OTP = 8'hA3;
  localparam logic [7:0] OP_LOCK_WRITE = 8'hA4;
  localparam logic [7:0] OP_LOCK_READ = 8'hA5;
  localparam logic [7:0] OP_PL_SET = 8'hA6;
  localparam logic [7:0] OP_PL_CLEAR_ALL = 8'hA7;
  localparam logic [7:0] OP_PL_READ = 8'hA8;
  localparam logic [7:0] OP_VL_WRITE = 8'hA9;
  localparam logic [7:0] OP_VL_READ = 8'hAA;
  localparam logic [7:0] OP_GANG_LOCK = 8'h7E;
  localparam logic [7:0] OP_GANG_UNLOCK = 8'h98;

  // Frame lengths in serial clock bits
  localparam logic [6:0] LEN_OPCODE = 7'h08;
  localparam logic [6:0] LEN_LOCK_WRITE = 7'h10;
  localparam logic [6:0] LEN_ADDR_CMD = 7'h28;
  localparam logic [6:0] LEN_ADDR_DATA = 7'h30;
  localparam logic [6:0] LEN_SAT = 7'h7F;

  // Lock register layout
  localparam int FREEZE_BIT = 6;
  localparam int PWMODE_BIT = 2;
  localparam logic [7:0] LOCK_RESET = 8'h44;

  // Lock bit array geometry
  localparam int NUM_LOCKS = 1054;
  localparam logic [9:0] TOP_BLOCK = 10'h3FF;
  localparam logic [10:0] TOP_SECTOR_BASE = 11'h010;
  localparam logic [10:0] MID_BLOCK_BASE = 11'h01F;
  localparam logic [15:0] ARRAY_BLOCKS = 16'h0400;

  // Lock read answers
  localparam logic [7:0] LOCK_READ_ONE = 8'hFF;
  localparam logic [7:0] LOCK_READ_ZERO = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_EXEC = 2'b11
  } frame_state_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic si;
  } link_pins_t;

endpackage : flash_prot_pkg

// [rtl/flash_sector_write_protection.sv]
// Serial command decoder with scheme select, lock register and sector lock bits
`timescale 1ns/1ns

module flash_sector_write_protection (
  input wire logic clk, // System clock, 50 MHz
  input wire logic rstn, // Power-up reset, async, active low
  input wire flash_prot_pkg::link_pins_t link, // Select, serial clock, serial in from host
  output logic so, // Serial data out
  output logic so_oe, // Serial out drive enable
  input wire logic reset_pin_n, // Hardware reset pin, active low
  input wire logic pwd_unlock_ok, // One-cycle pulse: password unlock matched
  input wire logic [3:0] status_protect_level_bits, // Status register level bits
  input wire logic [31:0] query_addr, // Address of a pending program or erase
  output logic query_protected, // Queried address is write protected
  output logic protection_scheme_select, // 1 = per-sector protection
  output logic secure_otp_active, // Secured OTP region selected
  output logic write_enable_latch, // Write enable latch state
  output logic [7:0] sector_lock_config // Lock register contents
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic [1:0] pin_prev_q;
  logic rst_s1_q;
  logic rst_s2_q;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_low;
  logic hold_rst;

  // Two flops per pin; only the second stage feeds logic
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      // Idle levels (select high, serial clock low) so release shows no false edge
      pin_s1_q <= 3'h4;
      pin_s2_q <= 3'h4;
      pin_prev_q <= 2'h2;
      rst_s1_q <= 1'b1;
      rst_s2_q <= 1'b1;
    end else begin
      pin_s1_q <= link;
      pin_s2_q <= pin_s1_q;
      pin_prev_q <= pin_s2_q[2:1];
      rst_s1_q <= reset_pin_n;
      rst_s2_q <= rst_s1_q;
    end
  end

  assign cs_low = ~pin_s2_q[2];
  assign sclk_rise = pin_s2_q[1] & ~pin_prev_q[0] & cs_low;
  assign sclk_fall = ~pin_s2_q[1] & pin_prev_q[0] & cs_low;
  assign hold_rst = ~rst_s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Frame state, bit shifter and byte capture

  flash_prot_pkg::frame_state_t state_q;
  logic [6:0] bit_cnt_q;
  logic [6:0] sh_q;
  logic [7:0] opcode_q;
  logic [31:0] addr_q;
  logic [7:0] data_q;
  logic [7:0] new_byte;
  logic byte_done;
  logic [31:0] addr_next;

  assign new_byte = {sh_q, pin_s2_q[0]};
  assign byte_done = sclk_rise && (bit_cnt_q[2:0] == 3'h7);
  assign addr_next = {addr_q[23:0], new_byte};

  // Frame framing: opened by select low, executed once at select high
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= flash_prot_pkg::ST_IDLE;
    end else if (hold_rst) begin
      state_q <= flash_prot_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        flash_prot_pkg::ST_IDLE: if (cs_low) state_q <= flash_prot_pkg::ST_SHIFT;
        flash_prot_pkg::ST_SHIFT: if (!cs_low) state_q <= flash_prot_pkg::ST_EXEC;
        flash_prot_pkg::ST_EXEC: state_q <= flash_prot_pkg::ST_IDLE;
        default: state_q <= flash_prot_pkg::ST_IDLE;
      endcase
    end
  end

  // Counter saturates so an over-long frame never wraps into a legal length
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_q <= 7'h00;
      sh_q <= 7'h00;
    end else if (state_q == flash_prot_pkg::ST_IDLE) begin
      bit_cnt_q <= 7'h00;
    end else if (sclk_rise) begin
      sh_q <= new_byte[6:0];
      if (bit_cnt_q != flash_prot_pkg::LEN_SAT) bit_cnt_q <= bit_cnt_q + 7'h01;
    end
  end

  // Byte 0 is the opcode, bytes 1 to 4 the address, the last byte the data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      opcode_q <= 8'h00;
      addr_q <= 32'h0000_0000;
      data_q <= 8'h00;
    end else if (byte_done) begin
      data_q <= new_byte;
      if (bit_cnt_q[6:3] == 4'h0) opcode_q <= new_byte;
      else if (bit_cnt_q[6:3] <= 4'h4) addr_q <= addr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sector index: 4KB sectors at both ends, 64KB blocks between

  function automatic logic [10:0] lock_index(input logic [31:0] a);
    logic [9:0] blk;
    blk = a[25:16];
    if (blk == 10'h000) lock_index = {7'h00, a[15:12]};
    else if (blk == flash_prot_pkg::TOP_BLOCK) lock_index = flash_prot_pkg::TOP_SECTOR_BASE + {7'h00, a[15:12]};
    else lock_index = flash_prot_pkg::MID_BLOCK_BASE + {1'b0, blk};
  endfunction : lock_index

  ////////////////////////////////////////////////////////////////////////////
  // Command decode at the end of a frame

  logic scheme_q;
  logic we_q;
  logic otp_q;
  logic [7:0] lock_q;
  logic [flash_prot_pkg::NUM_LOCKS-1:0] pers_q;
  logic [flash_prot_pkg::NUM_LOCKS-1:0] vol_q;
  logic exec;
  logic [6:0] exp_len;
  logic len_ok;
  logic freeze;
  logic do_scheme;
  logic do_lock_wr;
  logic do_pl_set;
  logic do_pl_clr;
  logic do_vl_wr;
  logic do_gang_lock;
  logic do_gang_unlock;
  logic [10:0] cmd_idx;

  assign exec = (state_q == flash_prot_pkg::ST_EXEC) && !hold_rst;
  assign freeze = lock_q[flash_prot_pkg::FREEZE_BIT];
  assign cmd_idx = lock_index(addr_q);

  // Expected frame length for each write-class opcode
  always_comb begin
    unique case (opcode_q)
      flash_prot_pkg::OP_LOCK_WRITE: exp_len = flash_prot_pkg::LEN_LOCK_WRITE;
      flash_prot_pkg::OP_PL_SET: exp_len = flash_prot_pkg::LEN_ADDR_CMD;
      flash_prot_pkg::OP_VL_WRITE: exp_len = flash_prot_pkg::LEN_ADDR_DATA;
      default: exp_len = flash_prot_pkg::LEN_OPCODE;
    endcase
  end

  assign len_ok = exec && (bit_cnt_q == exp_len);
  assign do_scheme = len_ok && we_q && (opcode_q == flash_prot_pkg::OP_SCHEME_SEL);
  assign do_lock_wr = len_ok && we_q && scheme_q && (opcode_q == flash_prot_pkg::OP_LOCK_WRITE);
  assign do_pl_set = len_ok && we_q && scheme_q && freeze && (opcode_q == flash_prot_pkg::OP_PL_SET);
  assign do_pl_clr = len_ok && we_q && scheme_q && freeze && (opcode_q == flash_prot_pkg::OP_PL_CLEAR_ALL);
  assign do_vl_wr = len_ok && we_q && scheme_q && (opcode_q == flash_prot_pkg::OP_VL_WRITE);
  assign do_gang_lock = len_ok && we_q && scheme_q && (opcode_q == flash_prot_pkg::OP_GANG_LOCK);
  assign do_gang_unlock = len_ok && we_q && scheme_q && (opcode_q == flash_prot_pkg::OP_GANG_UNLOCK);

  // Write enable latch: set by its command, dropped by any executed write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      we_q <= 1'b0;
    end else if (hold_rst) begin
      we_q <= 1'b0;
    end else if (len_ok && opcode_q == flash_prot_pkg::OP_WRITE_ENABLE) begin
      we_q <= 1'b1;
    end else if (do_scheme || do_lock_wr || do_pl_set || do_pl_clr || do_vl_wr || do_gang_lock || do_gang_unlock) begin
      we_q <= 1'b0;
    end
  end

  // One-time scheme bit: only ever written to 1
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) scheme_q <= 1'b0;
    else if (do_scheme) scheme_q <= 1'b1;
  end

  // Secured OTP region entry and exit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      otp_q <= 1'b0;
    end else if (hold_rst) begin
      otp_q <= 1'b0;
    end else if (len_ok && opcode_q == flash_prot_pkg::OP_ENTER_OTP) begin
      otp_q <= 1'b1;
    end else if (len_ok && opcode_q == flash_prot_pkg::OP_LEAVE_OTP) begin
      otp_q <= 1'b0;
    end
  end

  // Lock register; lock writes only program bits toward 0, password unlock sets the freeze bit, reserved bits stay 0
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lock_q <= flash_prot_pkg::LOCK_RESET;
    end else if (hold_rst) begin
      if (!lock_q[flash_prot_pkg::PWMODE_BIT]) lock_q[flash_prot_pkg::FREEZE_BIT] <= 1'b0;
    end else if (pwd_unlock_ok && scheme_q && !lock_q[flash_prot_pkg::PWMODE_BIT]) begin
      lock_q[flash_prot_pkg::FREEZE_BIT] <= 1'b1;
    end else if (do_lock_wr && lock_q[flash_prot_pkg::PWMODE_BIT] && freeze) begin
      // Solid mode with freeze still open; entering password mode closes freeze
      lock_q[flash_prot_pkg::PWMODE_BIT] <= data_q[flash_prot_pkg::PWMODE_BIT];
      lock_q[flash_prot_pkg::FREEZE_BIT] <= data_q[flash_prot_pkg::FREEZE_BIT]
                                            & data_q[flash_prot_pkg::PWMODE_BIT];
    end
  end

  // Persistent locks: single set, group clear, never touched while frozen
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) pers_q <= '0;
    else if (do_pl_clr) pers_q <= '0;
    else if (do_pl_set) pers_q[cmd_idx] <= 1'b1;
  end

  // Volatile locks come up protected, so per-sector mode starts locked
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) vol_q <= '1;
    else if (hold_rst) vol_q <= '1;
    else if (do_gang_lock) vol_q <= '1;
    else if (do_gang_unlock) vol_q <= '0;
    else if (do_vl_wr) vol_q[cmd_idx] <= |data_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read answers: loaded after the header, shifted on falling serial clock

  logic rd_active_q;
  logic [7:0] resp_q;
  logic [10:0] rd_idx_q;
  logic so_q;
  logic hdr_pl;
  logic hdr_vl;
  logic hdr_lock;
  logic [10:0] rd_idx;

  assign rd_idx = lock_index(addr_next);
  assign hdr_lock = byte_done && bit_cnt_q[6:3] == 4'h0 && new_byte == flash_prot_pkg::OP_LOCK_READ;
  assign hdr_pl = byte_done && bit_cnt_q[6:3] == 4'h4 && opcode_q == flash_prot_pkg::OP_PL_READ;
  assign hdr_vl = byte_done && bit_cnt_q[6:3] == 4'h4 && opcode_q == flash_prot_pkg::OP_VL_READ;

  // Answer byte repeats for as long as the host keeps clocking
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_active_q <= 1'b0;
      resp_q <= 8'h00;
      rd_idx_q <= 11'h000;
      so_q <= 1'b0;
    end else if (!cs_low || hold_rst) begin
      rd_active_q <= 1'b0;
    end else if (scheme_q && hdr_lock) begin
      rd_active_q <= 1'b1;
      resp_q <= lock_q;
    end else if (scheme_q && (hdr_pl || hdr_vl)) begin
      rd_active_q <= 1'b1;
      rd_idx_q <= rd_idx;
      if (hdr_pl) resp_q <= pers_q[rd_idx] ? flash_prot_pkg::LOCK_READ_ONE : flash_prot_pkg::LOCK_READ_ZERO;
      else resp_q <= vol_q[rd_idx] ? flash_prot_pkg::LOCK_READ_ONE : flash_prot_pkg::LOCK_READ_ZERO;
    end else if (rd_active_q && sclk_fall) begin
      so_q <= resp_q[7];
      resp_q <= {resp_q[6:0], resp_q[7]};
    end
  end

  assign so = so_q;
  assign so_oe = rd_active_q & cs_low;

  ////////////////////////////////////////////////////////////////////////////
  // Protection decision for program and erase requests

  logic prot_q;
  logic [15:0] level_blocks;
  logic [10:0] q_idx;

  assign q_idx = lock_index(query_addr);
  // Block-protect covers the top 2^(level-1) blocks
  assign level_blocks = (status_protect_level_bits == 4'h0) ? 16'h0000 :
                        (16'h0001 << (status_protect_level_bits - 4'h1));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) prot_q <= 1'b1;
    else if (scheme_q) prot_q <= pers_q[q_idx] | vol_q[q_idx];
    else prot_q <= ({6'h00, query_addr[25:16]} + level_blocks) >= flash_prot_pkg::ARRAY_BLOCKS;
  end

  assign query_protected = prot_q;
  assign protection_scheme_select = scheme_q;
  assign secure_otp_active = otp_q;
  assign write_enable_latch = we_q;
  assign sector_lock_config = lock_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_scheme_sticky: assert property (@(posedge clk) disable iff (!rstn) scheme_q |=> scheme_q)
    else $error("scheme select bit returned to 0");
  chk_scheme_needs_we: assert property (@(posedge clk) disable iff (!rstn) $rose(scheme_q) |-> $past(we_q))
    else $error("scheme select taken without write enable");
  chk_pers_frozen: assert property (@(posedge clk) disable iff (!rstn) !freeze |=> $stable(pers_q))
    else $error("persistent lock changed while frozen");
  chk_level_no_lock: assert property (@(posedge clk) disable iff (!rstn) !scheme_q |=> $stable(lock_q[6:2]))
    else $error("lock register changed in block-protect mode");
  chk_vol_reset: assert property (@(posedge clk) disable iff (!rstn) hold_rst |=> (&vol_q))
    else $error("volatile locks not protected after reset");
  chk_pw_permanent: assert property (@(posedge clk) disable iff (!rstn) !lock_q[2] |=> !lock_q[2])
    else $error("password mode left");
  chk_solid_frozen: assert property (@(posedge clk) disable iff (!rstn)
    (lock_q[2] && !lock_q[6]) |=> (lock_q[2] && !lock_q[6]))
    else $error("solid mode lock bits altered after freeze");
  chk_pl_read_value: assert property (@(posedge clk) disable iff (!rstn)
    ($rose(rd_active_q) && opcode_q == flash_prot_pkg::OP_PL_READ) |->
    resp_q == (pers_q[rd_idx_q] ? 8'hFF : 8'h00))
    else $error("persistent lock read byte wrong");
  chk_bad_len_ignored: assert property (@(posedge clk) disable iff (!rstn)
    (exec && bit_cnt_q != exp_len) |=> ($stable(pers_q) && $stable(scheme_q) && $stable(lock_q)))
    else $error("misframed command executed");
  chk_asp_combine: assert property (@(posedge clk) disable iff (!rstn)
    ($past(scheme_q) && !query_protected) |-> $past(!pers_q[q_idx] && !vol_q[q_idx]))
    else $error("sector open with a lock bit set");
  chk_otp_leave: assert property (@(posedge clk) disable iff (!rstn)
    (len_ok && opcode_q == flash_prot_pkg::OP_LEAVE_OTP) |=> !otp_q)
    else $error("secure OTP not left");

endmodule : flash_sector_write_protection

// [dv/host_model.sv]
// Host flash controller model that frames serial commands for the protection block
`timescale 1ns/1ns
module host_model (
  input wire logic clk, // System clock
  output flash_prot_pkg::link_pins_t link, // Select, serial clock, serial in
  input wire logic so, // Serial data from device
  input wire logic so_oe // Device drive enable
);
  //////////////////////////////////////////////////////////////////////////////
  // Idle link: deselected, serial clock parked low between frames
  initial begin
    link = '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0};
  end

  //////////////////////////////////////////////////////////////////////////////
  // One frame: n header bits MSB first, then nrd answer bits, then deselect
  // Answer bits taken late in the high phase, long after the device shifts so
  task automatic xfer(input logic [47:0] d, input int n, input int nrd, output logic [7:0] rd);
    rd = 8'h00;
    @(negedge clk);
    link.cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      link.sclk = 1'b0;
      link.si = d[i];
      repeat (4) @(negedge clk);
      link.sclk = 1'b1;
      repeat (4) @(negedge clk);
    end
    // Unused input toggles so a stale level never looks like data
    for (int i = 7; i >= 8 - nrd; i--) begin
      link.sclk = 1'b0;
      link.si = ~link.si;
      repeat (4) @(negedge clk);
      link.sclk = 1'b1;
      repeat (3) @(negedge clk);
      rd[i] = (so_oe === 1'b1) ? so : 1'bx;
      @(negedge clk);
    end
    link.sclk = 1'b0;
    repeat (4) @(negedge clk);
    link.cs_n = 1'b1;
    link.si = ~link.si;
    // Gap covers sync pipeline plus execution before the next frame
    repeat (12) @(negedge clk);
  endtask : xfer
endmodule : host_model

// [dv/tb.sv]
// Self-checking testbench for the sector write-protection block
`timescale 1ns/1ns
module tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic reset_pin_n = 1'b1;
  logic pwd_unlock_ok = 1'b0;
  logic [3:0] status_protect_level_bits = 4'h0;
  logic [31:0] query_addr = 32'h0000_0000;
  flash_prot_pkg::link_pins_t link;
  logic so;
  logic so_oe;
  logic query_protected;
  logic protection_scheme_select;
  logic secure_otp_active;
  logic write_enable_latch;
  logic [7:0] sector_lock_config;
  logic [7:0] rd;
  int bad_count = 0;
  int comparisons = 0;

  // 50 MHz clock
  always #10 clk = ~clk;

  host_model u_host (.clk(clk), .link(link), .so(so), .so_oe(so_oe));

  flash_sector_write_protection u_dut (
    .clk(clk), .rstn(rstn), .link(link), .so(so), .so_oe(so_oe), .reset_pin_n(reset_pin_n),
    .pwd_unlock_ok(pwd_unlock_ok), .status_protect_level_bits(status_protect_level_bits),
    .query_addr(query_addr), .query_protected(query_protected),
    .protection_scheme_select(protection_scheme_select), .secure_otp_active(secure_otp_active),
    .write_enable_latch(write_enable_latch), .sector_lock_config(sector_lock_config)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Compare and report
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  //////////////////////////////////////////////////////////////////////////////
  // Command helpers; write-class commands get their own write enable frame first
  task automatic op1(input logic [7:0] op);
    u_host.xfer({40'h0, op}, 8, 0, rd);
  endtask : op1

  task automatic opa(input logic [7:0] op, input logic [31:0] a);
    u_host.xfer({8'h00, op, a}, 40, 0, rd);
  endtask : opa

  task automatic pl_set(input logic [31:0] a);
    op1(flash_prot_pkg::OP_WRITE_ENABLE);
    opa(flash_prot_pkg::OP_PL_SET, a);
  endtask : pl_set

  task automatic lock_wr(input logic [7:0] v);
    op1(flash_prot_pkg::OP_WRITE_ENABLE);
    u_host.xfer({32'h0, flash_prot_pkg::OP_LOCK_WRITE, v}, 16, 0, rd);
  endtask : lock_wr

  task automatic pl_rd(input logic [31:0] a, input logic [7:0] exp);
    u_host.xfer({8'h00, flash_prot_pkg::OP_PL_READ, a}, 40, 8, rd);
    check(rd, exp, "lock bit read");
  endtask : pl_rd

  // Registered query answer settles one clock after the address
  task automatic qchk(input logic [31:0] a, input logic exp);
    query_addr = a;
    repeat (3) @(negedge clk);
    check({7'h0, query_protected}, {7'h0, exp}, "query");
  endtask : qchk

  task automatic flags(input logic [2:0] exp);
    check({5'h0, protection_scheme_select, write_enable_latch, secure_otp_active}, {5'h0, exp}, "flags");
  endtask : flags

  task automatic do_reset;
    rstn = 1'b0;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    repeat (5) @(negedge clk);
  endtask : do_reset

  //////////////////////////////////////////////////////////////////////////////
  // Hang guard: a run that overstays counts as a mismatch
  initial begin
    #1000000;
    bad_count++;
    $display("MISMATCH at %0t: run did not finish", $time);
    end_of_test();
  end

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    do_reset();
    check(sector_lock_config, flash_prot_pkg::LOCK_RESET, "lock reset");
    flags(3'b000);
    qchk(32'h03FF_0000, 1'b0);
    status_protect_level_bits = 4'h1;
    qchk(32'h03FF_0000, 1'b1);
    qchk(32'h03FE_0000, 1'b0);
    status_protect_level_bits = 4'h2;
    qchk(32'h03FE_0000, 1'b1);
    // Scheme select with no latch, lock command in block mode, over-long frame
    op1(flash_prot_pkg::OP_SCHEME_SEL);
    flags(3'b000);
    op1(flash_prot_pkg::OP_WRITE_ENABLE);
    opa(flash_prot_pkg::OP_PL_SET, 32'h0000_1000);
    flags(3'b010);
    u_host.xfer({39'h0, flash_prot_pkg::OP_SCHEME_SEL, 1'b0}, 9, 0, rd);
    flags(3'b010);
    op1(flash_prot_pkg::OP_SCHEME_SEL);
    flags(3'b100);
    // Per-sector mode: all protected at start, level bits ignored
    status_protect_level_bits = 4'h0;
    qchk(32'h0005_0000, 1'b1);
    op1(flash_prot_pkg::OP_WRITE_ENABLE);
    op1(flash_prot_pkg::OP_GANG_UNLOCK);
    status_protect_level_bits = 4'hF;
    qchk(32'h0005_0000, 1'b0);
    // Persistent bits: 4KB granularity at both ends, 64KB in the middle
    pl_rd(32'h0000_1000, flash_prot_pkg::LOCK_READ_ZERO);
    pl_set(32'h0000_1000);
    pl_set(32'h03FF_F000);
    pl_set(32'h0005_0000);
    pl_rd(32'h0000_1FFF, 8'hFF);
    pl_rd(32'h0000_2000, 8'h00);
    pl_rd(32'h03FF_E000, 8'h00);
    pl_rd(32'h03FF_F000, 8'hFF);
    pl_rd(32'h0005_F000, 8'hFF);
    pl_rd(32'h0004_F000, 8'h00);
    qchk(32'h0000_1800, 1'b1);
    qchk(32'h0000_2000, 1'b0);
    opa(flash_prot_pkg::OP_PL_SET, 32'h0000_3000);
    pl_rd(32'h0000_3000, 8'h00);
    op1(flash_prot_pkg::OP_WRITE_ENABLE);
    op1(flash_prot_pkg::OP_PL_CLEAR_ALL);
    pl_rd(32'h0000_1000, 8'h00);
    pl_rd(32'h0005_0000, 8'h00);
    qchk(32'h0000_1800, 1'b0);
    // Volatile bit alone protects its sector
    op1(flash_prot_pkg::OP_WRITE_ENABLE);
    u_host.xfer({flash_prot_pkg::OP_VL_WRITE, 32'h0006_0000, 8'h01}, 48, 0, rd);
    qchk(32'h0006_0000, 1'b1);
    // Volatile read back, then gang lock, and a gang unlock refused without the latch
    u_host.xfer({8'h00, flash_prot_pkg::OP_VL_READ, 32'h0006_0000}, 40, 8, rd);
    check(rd, flash_prot_pkg::LOCK_READ_ONE, "volatile read set");
    u_host.xfer({8'h00, flash_prot_pkg::OP_VL_READ, 32'h0007_0000}, 40, 8, rd);
    check(rd, flash_prot_pkg::LOCK_READ_ZERO, "volatile read clear");
    op1(flash_prot_pkg::OP_WRITE_ENABLE);
    op1(flash_prot_pkg::OP_GANG_LOCK);
    qchk(32'h0005_0000, 1'b1);
    op1(flash_prot_pkg::OP_GANG_UNLOCK);
    qchk(32'h0005_0000, 1'b1);
    // Lock register: read back, freeze in solid mode, then frozen
    u_host.xfer({40'h0, flash_prot_pkg::OP_LOCK_READ}, 8, 8, rd);
    check(rd, 8'h44, "lock read");
    lock_wr(8'h04);
    check(sector_lock_config, 8'h04, "freeze");
    pl_set(32'h0000_1000);
    pl_rd(32'h0000_1000, 8'h00);
    lock_wr(8'h44);
    check(sector_lock_config, 8'h04, "frozen");
    lock_wr(8'h40);
    check(sector_lock_config, 8'h04, "frozen mode");
    // Fresh device into password mode; password assumed already stored
    do_reset();
    check(sector_lock_config, 8'h44, "second reset");
    op1(flash_prot_pkg::OP_WRITE_ENABLE);
    op1(flash_prot_pkg::OP_SCHEME_SEL);
    lock_wr(8'h40);
    check(sector_lock_config, 8'h00, "password mode");
    pl_set(32'h0000_1000);
    pl_rd(32'h0000_1000, 8'h00);
    pwd_unlock_ok = 1'b1;
    @(negedge clk);
    pwd_unlock_ok = 1'b0;
    repeat (3) @(negedge clk);
    check(sector_lock_config, 8'h40, "unlocked");
    pl_set(32'h0000_1000);
    pl_rd(32'h0000_1000, 8'hFF);
    lock_wr(8'h44);
    check(sector_lock_config, 8'h40, "mode kept");
    op1(flash_prot_pkg::OP_WRITE_ENABLE);
    op1(flash_prot_pkg::OP_GANG_UNLOCK);
    qchk(32'h0005_0000, 1'b0);
    // Pin reset: volatile state back to protected, persistent state kept
    op1(flash_prot_pkg::OP_WRITE_ENABLE);
    reset_pin_n = 1'b0;
    repeat (5) @(negedge clk);
    check(sector_lock_config, 8'h00, "pin reset");
    flags(3'b100);
    reset_pin_n = 1'b1;
    repeat (5) @(negedge clk);
    qchk(32'h0005_0000, 1'b1);
    pl_rd(32'h0000_1000, 8'hFF);
    // Secured region entry and exit, over-long exit frame refused
    op1(flash_prot_pkg::OP_ENTER_OTP);
    flags(3'b101);
    u_host.xfer({39'h0, flash_prot_pkg::OP_LEAVE_OTP, 1'b1}, 9, 0, rd);
    flags(3'b101);
    op1(flash_prot_pkg::OP_LEAVE_OTP);
    flags(3'b100);
    end_of_test();
  end
endmodule : tb
